// ==== rtl/pbr_pkg.sv ====
package pbr_pkg;
    // Serial request framing on the link request line
    localparam int REQ_TYPE_BITS = 3;
    localparam int REQ_ADDR_BITS = 4;
    localparam int REQ_DATA_BITS = 8;
    localparam int BUS_REQ_BODY_BITS = 3;
    localparam int ACCEL_BODY_BITS = 2;
    localparam int RD_BODY_BITS = REQ_ADDR_BITS + 1;
    localparam int WR_BODY_BITS = REQ_ADDR_BITS + REQ_DATA_BITS + 1;

    // Request type codes carried in the second to fourth bits
    localparam logic [2:0] REQ_IMM = 3'h0;
    localparam logic [2:0] REQ_ISO = 3'h1;
    localparam logic [2:0] REQ_PRI = 3'h2;
    localparam logic [2:0] REQ_FAIR = 3'h3;
    localparam logic [2:0] REQ_RD = 3'h4;
    localparam logic [2:0] REQ_WR = 3'h5;
    localparam logic [2:0] REQ_ACCEL = 3'h6;
    localparam logic [2:0] REQ_RSVD = 3'h7;

    // Register addresses
    localparam logic [3:0] ADDR_RESET_HOLDOFF_GAP = 4'h1;
    localparam logic [3:0] ADDR_ARBITRATION_FEATURE = 4'h5;

    // Field layout of reset_holdoff_gap_reg (first transmitted bit is bit 7)
    localparam int ROOT_HOLDOFF_BIT = 7;
    localparam int LONG_RESET_BIT = 6;
    localparam int GAP_MSB = 5;
    localparam int GAP_LSB = 0;

    // Field layout of arbitration_feature_reg
    localparam int SHORT_RESET_BIT = 6;

    // Reset values and the forced gap count
    localparam logic [5:0] GAP_COUNT_MAX = 6'h3F;
    localparam logic [5:0] GAP_COUNT_RESET = 6'h3F;
    localparam logic ROOT_HOLDOFF_RESET = 1'b0;
    localparam logic [7:0] ARB_FEATURE_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    typedef enum logic [1:0] {
        PBR_IDLE,
        PBR_TYPE,
        PBR_BODY
    } pbr_dec_state_t;
endpackage : pbr_pkg

// ==== rtl/pbr_req_decoder.sv ====
`timescale 1ns/1ns
// Serial request decoder: collects a request stream, reports register reads and writes
module pbr_req_decoder
    import pbr_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic req_bit,
    output logic rd_pulse,
    output logic wr_pulse,
    output logic [3:0] req_addr,
    output logic [7:0] req_data
);
    localparam int CNT_W = 5;

    pbr_dec_state_t state_r;
    logic [CNT_W-1:0] cnt_r;
    logic [2:0] type_r;
    logic [WR_BODY_BITS-1:0] shift_r;
    logic [CNT_W-1:0] body_len;

    // Body length after the type field, stop bit included
    always_comb begin
        unique case (type_r)
            REQ_RD: body_len = CNT_W'(RD_BODY_BITS);
            REQ_WR: body_len = CNT_W'(WR_BODY_BITS);
            REQ_ACCEL: body_len = CNT_W'(ACCEL_BODY_BITS);
            REQ_IMM, REQ_ISO, REQ_PRI, REQ_FAIR, REQ_RSVD: body_len = CNT_W'(BUS_REQ_BODY_BITS);
        endcase
    end

    // Frame sequencer: start bit, type, body; trailing extra stop bits fall in idle
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= PBR_IDLE;
            cnt_r <= '0;
            type_r <= REQ_IMM;
        end else begin
            unique case (state_r)
                PBR_IDLE: begin
                    cnt_r <= '0;
                    if (req_bit) begin
                        state_r <= PBR_TYPE;
                    end
                end
                PBR_TYPE: begin
                    type_r <= {type_r[1:0], req_bit};
                    if (cnt_r == CNT_W'(REQ_TYPE_BITS - 1)) begin
                        cnt_r <= '0;
                        state_r <= PBR_BODY;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                PBR_BODY: begin
                    if (cnt_r == body_len - 1'b1) begin
                        state_r <= PBR_IDLE;
                        cnt_r <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
            endcase
        end
    end

    // Body shift register, first bit ends up most significant
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_r <= '0;
        end else if (state_r == PBR_BODY) begin
            shift_r <= {shift_r[WR_BODY_BITS-2:0], req_bit};
        end
    end

    // One-cycle completion strobes, fired on the stop bit
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_pulse <= 1'b0;
            wr_pulse <= 1'b0;
        end else begin
            rd_pulse <= (state_r == PBR_BODY) && (cnt_r == body_len - 1'b1) && (type_r == REQ_RD);
            wr_pulse <= (state_r == PBR_BODY) && (cnt_r == body_len - 1'b1) && (type_r == REQ_WR);
        end
    end

    // Address and data fields; shift_r already holds the stop bit in bit 0 during the strobe cycle
    always_comb begin
        if (type_r == REQ_RD) begin
            req_addr = shift_r[RD_BODY_BITS-1 -: REQ_ADDR_BITS];
            req_data = READ_ZERO;
        end else begin
            req_addr = shift_r[WR_BODY_BITS-1 -: REQ_ADDR_BITS];
            req_data = shift_r[REQ_DATA_BITS:1];
        end
    end
endmodule : pbr_req_decoder

// ==== rtl/pbr_reset_gap_ctrl.sv ====
`timescale 1ns/1ns
// Function
// - Writing one to short-reset trigger in register 5 starts an arbitrated short reset.
// - Writing one to long-reset trigger in register 1 starts reset and initialization.
// - Register 1 write loads trigger, root holdoff and gap count together.
// - Sent or received configuration packets load root holdoff and gap count.
// - Two bus resets without intervening gap write force gap count to 63.
// - Reset started by register 1 trigger write keeps the just-written gap count.
// - After sending a configuration packet, register 1 shows updated holdoff and gap.
module pbr_reset_gap_ctrl
    import pbr_pkg::*;
#(
    parameter int SYNC_STAGES = 2
) (
    input wire logic clk,
    input wire logic rst,
    // Serial request line from the link controller
    input wire logic link_request_line,
    // Configuration packet events from the packet logic
    input wire logic cfg_pkt_rx,
    input wire logic cfg_pkt_tx,
    input wire logic cfg_root_holdoff,
    input wire logic [5:0] cfg_gap_count,
    // Bus state machine handshake
    input wire logic bus_reset_begun,
    input wire logic bus_reset_seen,
    output logic short_reset_req,
    output logic long_reset_req,
    // Register read answer
    output logic rd_valid,
    output logic [3:0] rd_addr,
    output logic [7:0] rd_data,
    // Present settings
    output logic root_holdoff_flag,
    output logic [5:0] gap_count,
    output logic [7:0] arb_features
);
    // The synchronizer needs two stages before the decoder may read the line
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("SYNC_STAGES must be at least 2");
    end

    // The gap field layout must match the packet gap count width
    if (GAP_MSB - GAP_LSB + 1 != $bits(cfg_gap_count)) begin : g_bad_gap
        $error("Gap field width differs from the packet gap count width");
    end

    // Request line synchronizer and decoder results
    logic [SYNC_STAGES-1:0] req_sync_r;
    logic req_bit;
    logic dec_rd;
    logic dec_wr;
    logic [3:0] dec_addr;
    logic [7:0] dec_data;

    // Register state and read answer
    logic root_holdoff_flag_r;
    logic [5:0] gap_count_r;
    logic long_reset_trigger_r;
    logic short_reset_trigger_r;
    logic [7:0] arb_feature_r;
    logic gap_written_r;
    logic rd_valid_r;
    logic [3:0] rd_addr_r;
    logic [7:0] rd_data_r;

    // Decoded write strobes and packet load
    logic wr_reg1;
    logic wr_reg5;
    logic cfg_load;

    // Register image decoding used by the read path
    function automatic logic [7:0] reg_image(
        input logic [3:0] addr,
        input logic holdoff,
        input logic long_trig,
        input logic [5:0] gap,
        input logic short_trig,
        input logic [7:0] arb
    );
        logic [7:0] img;
        img = READ_ZERO;
        if (addr == ADDR_RESET_HOLDOFF_GAP) begin
            img[ROOT_HOLDOFF_BIT] = holdoff;
            img[LONG_RESET_BIT] = long_trig;
            img[GAP_MSB:GAP_LSB] = gap;
        end else if (addr == ADDR_ARBITRATION_FEATURE) begin
            img = arb;
            img[SHORT_RESET_BIT] = short_trig;
        end
        return img;
    endfunction : reg_image

    // Request line crosses in from the link side through a synchronizer
    always_ff @(posedge clk) begin
        if (rst) begin
            req_sync_r <= '0;
        end else begin
            req_sync_r <= {req_sync_r[SYNC_STAGES-2:0], link_request_line};
        end
    end

    assign req_bit = req_sync_r[SYNC_STAGES-1];

    // Serial request decoding of read and write requests
    pbr_req_decoder u_dec (
        .clk(clk),
        .rst(rst),
        .req_bit(req_bit),
        .rd_pulse(dec_rd),
        .wr_pulse(dec_wr),
        .req_addr(dec_addr),
        .req_data(dec_data)
    );

    // Write strobe for one register address
    function automatic logic wr_hit(input logic [3:0] target);
        return dec_wr && (dec_addr == target);
    endfunction : wr_hit

    // Write decode
    assign wr_reg1 = wr_hit(ADDR_RESET_HOLDOFF_GAP);
    assign wr_reg5 = wr_hit(ADDR_ARBITRATION_FEATURE);
    assign cfg_load = cfg_pkt_rx || cfg_pkt_tx;

    // Root holdoff: register 1 write wins over a packet in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            root_holdoff_flag_r <= ROOT_HOLDOFF_RESET;
        end else if (wr_reg1) begin
            root_holdoff_flag_r <= dec_data[ROOT_HOLDOFF_BIT];
        end else if (cfg_load) begin
            root_holdoff_flag_r <= cfg_root_holdoff;
        end
    end

    // Gap count: loads from writes and packets, forced to maximum on idle resets
    always_ff @(posedge clk) begin
        if (rst) begin
            gap_count_r <= GAP_COUNT_RESET;
        end else if (wr_reg1) begin
            gap_count_r <= dec_data[GAP_MSB:GAP_LSB];
        end else if (cfg_load) begin
            gap_count_r <= cfg_gap_count;
        end else if (bus_reset_seen && !gap_written_r) begin
            gap_count_r <= GAP_COUNT_MAX;
        end
    end

    // Tracks a gap write since the last bus reset; a write in the reset cycle wins
    always_ff @(posedge clk) begin
        if (rst) begin
            gap_written_r <= 1'b0;
        end else if (wr_reg1 || cfg_load) begin
            gap_written_r <= 1'b1;
        end else if (bus_reset_seen) begin
            gap_written_r <= 1'b0;
        end
    end

    // Long reset trigger: set by write, cleared once the reset has begun
    always_ff @(posedge clk) begin
        if (rst) begin
            long_reset_trigger_r <= 1'b0;
        end else if (wr_reg1 && dec_data[LONG_RESET_BIT]) begin
            long_reset_trigger_r <= 1'b1;
        end else if (bus_reset_begun) begin
            long_reset_trigger_r <= 1'b0;
        end
    end

    // Short reset trigger: set by write, cleared once the reset has begun
    always_ff @(posedge clk) begin
        if (rst) begin
            short_reset_trigger_r <= 1'b0;
        end else if (wr_reg5 && dec_data[SHORT_RESET_BIT]) begin
            short_reset_trigger_r <= 1'b1;
        end else if (bus_reset_begun) begin
            short_reset_trigger_r <= 1'b0;
        end
    end

    // Other writable bits of register 5 are stored as written
    always_ff @(posedge clk) begin
        if (rst) begin
            arb_feature_r <= ARB_FEATURE_RESET;
        end else if (wr_reg5) begin
            arb_feature_r <= dec_data & ~(8'h01 << SHORT_RESET_BIT);
        end
    end

    // Read answer, one cycle after the read request completes
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_valid_r <= 1'b0;
            rd_addr_r <= '0;
            rd_data_r <= READ_ZERO;
        end else begin
            rd_valid_r <= dec_rd;
            if (dec_rd) begin
                rd_addr_r <= dec_addr;
                rd_data_r <= reg_image(dec_addr, root_holdoff_flag_r, long_reset_trigger_r,
                                       gap_count_r, short_reset_trigger_r,
                                       arb_feature_r);
            end
        end
    end

    // Outputs straight from flip-flops
    assign short_reset_req = short_reset_trigger_r;
    assign long_reset_req = long_reset_trigger_r;
    assign rd_valid = rd_valid_r;
    assign rd_addr = rd_addr_r;
    assign rd_data = rd_data_r;
    assign root_holdoff_flag = root_holdoff_flag_r;
    assign gap_count = gap_count_r;
    assign arb_features = arb_feature_r;
endmodule : pbr_reset_gap_ctrl

// ==== tb/pbr_reset_gap_ctrl_props.sv ====
`timescale 1ns/1ns
// Port-level checks of reset triggers, gap count and read answers
module pbr_reset_gap_ctrl_props
    import pbr_pkg::*;
#(
    parameter int SYNC_STAGES = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_request_line,
    input wire logic cfg_pkt_rx,
    input wire logic cfg_pkt_tx,
    input wire logic cfg_root_holdoff,
    input wire logic [5:0] cfg_gap_count,
    input wire logic bus_reset_begun,
    input wire logic bus_reset_seen,
    input wire logic short_reset_req,
    input wire logic long_reset_req,
    input wire logic rd_valid,
    input wire logic [3:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic root_holdoff_flag,
    input wire logic [5:0] gap_count,
    input wire logic [7:0] arb_features
);
    logic mark_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Gap written since last bus reset: a packet or a freshly raised long trigger
    always_ff @(posedge clk) begin
        if (rst) begin
            mark_r <= 1'h0;
        end else if (cfg_pkt_rx || cfg_pkt_tx || $rose(long_reset_req)) begin
            mark_r <= 1'h1;
        end else if (bus_reset_seen) begin
            mark_r <= 1'h0;
        end
    end
    sequence s_seen_clean;
        bus_reset_seen && !mark_r;
    endsequence
    sequence s_seen_marked;
        bus_reset_seen && mark_r;
    endsequence
    property p_gap_forced;
        s_seen_clean |=> gap_count == GAP_COUNT_MAX;
    endproperty
    a_gap_forced: assert property (p_gap_forced)
        else $error("gap count not forced to maximum");
    property p_gap_kept;
        s_seen_marked |=> $stable(gap_count);
    endproperty
    a_gap_kept: assert property (p_gap_kept)
        else $error("written gap count lost on bus reset");
    property p_cfg_load;
        cfg_pkt_rx || cfg_pkt_tx |=> gap_count == $past(cfg_gap_count)
            && root_holdoff_flag == $past(cfg_root_holdoff);
    endproperty
    a_cfg_load: assert property (p_cfg_load)
        else $error("packet values not loaded");
    property p_long_hold;
        long_reset_req && !bus_reset_begun |=> long_reset_req;
    endproperty
    a_long_hold: assert property (p_long_hold)
        else $error("long trigger dropped early");
    property p_short_hold;
        short_reset_req && !bus_reset_begun |=> short_reset_req;
    endproperty
    a_short_hold: assert property (p_short_hold)
        else $error("short trigger dropped early");
    property p_begun_clear;
        bus_reset_begun |=> !long_reset_req && !short_reset_req;
    endproperty
    a_begun_clear: assert property (p_begun_clear)
        else $error("trigger not cleared after reset began");
    property p_rd_pulse;
        rd_valid |=> !rd_valid;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("read answer longer than one cycle");
    property p_rd_reg1;
        rd_valid && rd_addr == ADDR_RESET_HOLDOFF_GAP
            |-> rd_data == {root_holdoff_flag, long_reset_req, gap_count};
    endproperty
    a_rd_reg1: assert property (p_rd_reg1)
        else $error("register 1 read differs from settings");
    property p_rd_reg5;
        rd_valid && rd_addr == ADDR_ARBITRATION_FEATURE
            |-> rd_data == {arb_features[7], short_reset_req, arb_features[5:0]};
    endproperty
    a_rd_reg5: assert property (p_rd_reg5)
        else $error("register 5 read differs from settings");
    property p_rd_none;
        rd_valid && rd_addr != ADDR_RESET_HOLDOFF_GAP
            && rd_addr != ADDR_ARBITRATION_FEATURE |-> rd_data == READ_ZERO;
    endproperty
    a_rd_none: assert property (p_rd_none)
        else $error("unmapped read not zero");
endmodule : pbr_reset_gap_ctrl_props

bind pbr_reset_gap_ctrl pbr_reset_gap_ctrl_props #(.SYNC_STAGES(SYNC_STAGES)) u_props (
    .clk(clk), .rst(rst), .link_request_line(link_request_line),
    .cfg_pkt_rx(cfg_pkt_rx), .cfg_pkt_tx(cfg_pkt_tx), .cfg_root_holdoff(cfg_root_holdoff),
    .cfg_gap_count(cfg_gap_count), .bus_reset_begun(bus_reset_begun),
    .bus_reset_seen(bus_reset_seen), .short_reset_req(short_reset_req),
    .long_reset_req(long_reset_req), .rd_valid(rd_valid), .rd_addr(rd_addr),
    .rd_data(rd_data), .root_holdoff_flag(root_holdoff_flag), .gap_count(gap_count),
    .arb_features(arb_features)
);

// ==== tb/pbr_link_model.sv ====
`timescale 1ns/1ns
// Link controller model: serial requests on the request line
module pbr_link_model (
    input wire logic clk,
    output logic link_request_line
);
    // Line idles low between requests
    initial link_request_line = 1'h0;
    // Start bit, type, body MSB first, then stop bit; one bit per clock
    task automatic send(input logic [2:0] typ, input logic [11:0] body, input int nb);
        logic [15:0] s;
        s = {1'h1, typ, body};
        for (int i = 0; i < 4 + nb; i++) begin
            @(posedge clk);
            #2;
            link_request_line = s[15 - i];
        end
        @(posedge clk);
        #2;
        link_request_line = 1'h0;
    endtask : send
endmodule : pbr_link_model

// ==== tb/tb_pbr_reset_gap_ctrl.sv ====
`timescale 1ns/1ns
// Bench for the reset trigger and gap count control
module tb_pbr_reset_gap_ctrl
    import pbr_pkg::*;
();
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic link_request_line;
    logic cfg_pkt_rx = 1'h0;
    logic cfg_pkt_tx = 1'h0;
    logic cfg_root_holdoff = 1'h0;
    logic [5:0] cfg_gap_count = 6'h00;
    logic bus_reset_begun = 1'h0;
    logic bus_reset_seen = 1'h0;
    logic short_reset_req, long_reset_req, rd_valid, root_holdoff_flag;
    logic [3:0] rd_addr;
    logic [7:0] rd_data, arb_features;
    logic [5:0] gap_count;
    int n_fail = 0;
    int n_checks = 0;

    // 20 MHz clock
    always #25 clk = ~clk;

    pbr_link_model u_link (.clk(clk), .link_request_line(link_request_line));
    pbr_reset_gap_ctrl u_dut (
        .clk(clk), .rst(rst), .link_request_line(link_request_line),
        .cfg_pkt_rx(cfg_pkt_rx), .cfg_pkt_tx(cfg_pkt_tx), .cfg_root_holdoff(cfg_root_holdoff),
        .cfg_gap_count(cfg_gap_count), .bus_reset_begun(bus_reset_begun),
        .bus_reset_seen(bus_reset_seen), .short_reset_req(short_reset_req),
        .long_reset_req(long_reset_req), .rd_valid(rd_valid), .rd_addr(rd_addr),
        .rd_data(rd_data), .root_holdoff_flag(root_holdoff_flag), .gap_count(gap_count),
        .arb_features(arb_features)
    );

    // Compare and count
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Register write; takes effect four edges after the stop bit
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        u_link.send(REQ_WR, {a, d}, 12);
        repeat (6) @(posedge clk);
        #2;
    endtask : wr
    // Register read; waits a bounded time for the answer pulse
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        int k = 0;
        u_link.send(REQ_RD, {a, 8'h00}, 4);
        while (rd_valid !== 1'h1 && k < 12) begin
            @(posedge clk);
            #1;
            k++;
        end
        check("rd_valid", {7'h0, rd_valid}, 8'h01);
        check("rd_addr", {4'h0, rd_addr}, {4'h0, a});
        check("rd_data", rd_data, exp);
        @(posedge clk);
        #2;
    endtask : rd
    // One-cycle pulses from the bus state machine
    task automatic pulse(input logic b, input logic s);
        @(posedge clk);
        #2;
        bus_reset_begun = b;
        bus_reset_seen = s;
        @(posedge clk);
        #2;
        bus_reset_begun = 1'h0;
        bus_reset_seen = 1'h0;
    endtask : pulse
    // Configuration packet sent or received
    task automatic cfg(input logic tx, input logic rh, input logic [5:0] g);
        @(posedge clk);
        #2;
        cfg_pkt_tx = tx;
        cfg_pkt_rx = !tx;
        cfg_root_holdoff = rh;
        cfg_gap_count = g;
        @(posedge clk);
        #2;
        cfg_pkt_tx = 1'h0;
        cfg_pkt_rx = 1'h0;
    endtask : cfg
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // Watchdog: the tests need well under 2000 cycles
    initial begin
        #(5000 * 50);
        n_fail++;
        print_verdict();
    end

    // Test sequence
    initial begin
        repeat (12) @(posedge clk);
        #2;
        rst = 1'h0;
        rd(ADDR_RESET_HOLDOFF_GAP, 8'h3F);
        rd(ADDR_ARBITRATION_FEATURE, 8'h00);
        $display("test reset values done");
        cfg(1'h1, 1'h1, 6'h2A);
        check("gap", {2'h0, gap_count}, 8'h2A);
        rd(ADDR_RESET_HOLDOFF_GAP, 8'hAA);
        pulse(1'h0, 1'h1);
        check("gap", {2'h0, gap_count}, 8'h2A);
        wr(ADDR_RESET_HOLDOFF_GAP, 8'hEA);
        check("long_req", {7'h0, long_reset_req}, 8'h01);
        rd(ADDR_RESET_HOLDOFF_GAP, 8'hEA);
        pulse(1'h1, 1'h1);
        check("long_req", {7'h0, long_reset_req}, 8'h00);
        check("gap", {2'h0, gap_count}, 8'h2A);
        pulse(1'h0, 1'h1);
        check("gap", {2'h0, gap_count}, 8'h3F);
        check("holdoff", {7'h0, root_holdoff_flag}, 8'h01);
        $display("test sent packet and long reset done");
        cfg(1'h0, 1'h0, 6'h10);
        check("gap", {2'h0, gap_count}, 8'h10);
        wr(ADDR_RESET_HOLDOFF_GAP, 8'h7F);
        check("gap", {2'h0, gap_count}, 8'h3F);
        pulse(1'h1, 1'h0);
        rd(ADDR_RESET_HOLDOFF_GAP, 8'h3F);
        $display("test received packet done");
        wr(ADDR_ARBITRATION_FEATURE, 8'h05);
        check("short_req", {7'h0, short_reset_req}, 8'h00);
        wr(ADDR_ARBITRATION_FEATURE, 8'h45);
        check("short_req", {7'h0, short_reset_req}, 8'h01);
        check("arb", arb_features, 8'h05);
        rd(ADDR_ARBITRATION_FEATURE, 8'h45);
        pulse(1'h1, 1'h0);
        rd(ADDR_ARBITRATION_FEATURE, 8'h05);
        $display("test short reset done");
        u_link.send(REQ_FAIR, {3'h5, 9'h000}, 3);
        u_link.send(REQ_ACCEL, {1'h1, 11'h000}, 1);
        wr(4'h2, 8'h99);
        rd(4'h2, 8'h00);
        rd(4'hF, 8'h00);
        check("gap", {2'h0, gap_count}, 8'h3F);
        $display("test refused requests done");
        print_verdict();
    end
endmodule : tb_pbr_reset_gap_ctrl
